/* dv/ams_filt_model.sv */
/*
  Decimation filter model: answers each go with one finished pulse.
  Assumes go arrives on mclk; the answer delay is set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ams_filt_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Sequencer side
  input  wire logic        filter_go,
  input  wire logic [4:0]  result_width,
  input  wire logic [7:0]  filter_delay,
  output var  logic        filter_finished,
  output var  logic [23:0] filter_data
);
  logic        busy;
  logic [7:0]  cnt;
  logic [23:0] val;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      val <= 24'h2a_4c6d;
      filter_finished <= 1'b0;
      filter_data <= 24'h00_0000;
    end else begin
      filter_finished <= 1'b0;
      // Data keeps changing when not valid, so a late sample cannot match by luck
      filter_data <= ~filter_data;
      if (filter_go) begin
        busy <= 1'b1;
        cnt <= filter_delay;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        filter_finished <= 1'b1;
        filter_data <= val & ((24'h00_0001 << result_width) - 24'h00_0001);
        val <= val + 24'h13_579b;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // ams_filt_model
`default_nettype wire

/* dv/ams_seq_chk.sv */
/*
  Port checker for the input multiplexer sequencer.
  Assumes the slow clock runs far below mclk, low and high for 8+ mclk each.
*/
`timescale 1ns/1ps
`default_nettype none
module ams_seq_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Sequencer ports watched
  input wire logic        slow_crystal_clock,
  input wire logic        filter_go,
  input wire logic [1:0]  filter_length,
  input wire logic [4:0]  result_width,
  input wire logic        filter_finished,
  input wire logic [23:0] filter_data,
  input wire logic        ram_we,
  input wire logic [3:0]  ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic        ce_pass_start,
  input wire logic [3:0]  mux_select,
  input wire logic        frame_sync_pulse,
  input wire logic        phase_a_differential,
  input wire logic        phase_a_return_swap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_go_single: assert property (filter_go |=> !filter_go [*8])
    else $error("filter go repeated too soon");
  a_go_on_slow: assert property (filter_go |-> slow_crystal_clock && !$past(slow_crystal_clock, 8))
    else $error("filter go not tied to a slow rising edge");
  a_ram_data: assert property (ram_we |-> $past(filter_finished) && ram_wdata == {$past(filter_data), 8'h00})
    else $error("ram word not shifted filter result");
  a_ram_word: assert property (ram_we |-> ram_addr == $past(mux_select))
    else $error("ram word not the selected input");
  a_pass_slot0: assert property (ce_pass_start |-> filter_go)
    else $error("engine pass without slot start");
  a_sync_quiet: assert property (frame_sync_pulse |-> !filter_go)
    else $error("conversion started in sync cycle");
  a_sync_long: assert property ($rose(frame_sync_pulse) |=> frame_sync_pulse [*8])
    else $error("sync pulse shorter than a slow cycle");
  logic width_ok;
  assign width_ok = (filter_length == 2'h0 && result_width inside {5'h12, 5'h13})
    || (filter_length == 2'h1 && result_width inside {5'h15, 5'h16})
    || (filter_length == 2'h2 && result_width inside {5'h16, 5'h18});
  a_width_len: assert property (width_ok)
    else $error("result width does not match length");
  a_mux_moves: assert property ($changed(mux_select) |-> filter_go)
    else $error("mux moved without a conversion start");
  a_swap_diff: assert property (phase_a_return_swap |-> phase_a_differential)
    else $error("return swap while single ended");
  c_pass: cover property (ce_pass_start);
  c_batt: cover property (ram_we && ram_addr == 4'hb);
  c_sync: cover property ($rose(frame_sync_pulse));
endmodule // ams_seq_chk
bind ams_seq ams_seq_chk i_ams_seq_chk (.*);
`default_nettype wire

/* dv/tb_top.sv */
/*
  Self-checking bench for the sequencer with the filter model.
  Assumes 40 MHz mclk; the slow clock is sped up to 1 MHz to keep runs short.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rst, reg_wr, reg_rd, slow_crystal_clock, filter_go, filter_finished;
  logic        ram_we, ce_pass_start, chop_polarity, frame_sync_pulse, battery_path_enable;
  logic        phase_a_differential, phase_b_differential, phase_a_return_swap;
  logic        phase_b_return_swap, p;
  logic [1:0]  filter_length;
  logic [3:0]  ram_addr, mux_select;
  logic [4:0]  result_width;
  logic [7:0]  filter_delay;
  logic [15:0] reg_addr;
  logic [23:0] filter_data;
  logic [31:0] reg_wdata, reg_rdata, ram_wdata;
  logic [3:0]  q[$];
  logic        pq[$];
  logic        cq[$];
  int          error_cnt, samples_checked, gap;
  logic [23:0] rows [6] = '{24'h00_0412, 24'h08_5416, 24'h18_2418,
                            24'h28_0413, 24'h04_1415, 24'h0c_2416};
  logic [3:0]  exp9 [9] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'h1, 4'hb, 4'h0, 4'h1, 4'h2};
  logic [15:0] gaps [4] = '{16'h0328, 16'h1350, 16'h2378, 16'h0350};

  ams_seq i_ams_seq (.*);
  ams_filt_model i_ams_filt_model (.*);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    slow_crystal_clock = 1'b0;
    #7;
    forever #500 slow_crystal_clock = ~slow_crystal_clock;
  end
  always @(negedge mclk) begin
    if (ram_we === 1'b1) begin
      q.push_back(ram_addr);
      cq.push_back(chop_polarity);
      if (ram_addr == 4'ha)
        pq.push_back(chop_polarity);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  task automatic wsync(input int n);
    repeat (n) @(posedge frame_sync_pulse);
    repeat (2) @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 50'h0};
    filter_delay = 8'h03;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(16'h2020, 32'h0002_0004);
    rd(16'h2030, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(16'h2020, {16'h0002, rows[i][23:8]});
      repeat (2) @(negedge mclk);
      chk({battery_path_enable, phase_a_differential, phase_b_differential, filter_length,
           result_width}, {rows[i][14], rows[i][20], rows[i][21], rows[i][13:12],
           rows[i][4:0]});
    end
    wr(16'h2040, 32'h0000_00a0);
    wr(16'h2044, 32'h0000_0011);
    wr(16'h2048, 32'h0000_00b2);
    rd(16'h2044, 32'h0000_0011);
    wr(16'h2064, 32'h0000_0093);
    rd(16'h2064, 32'h0000_0093);
    wr(16'h2020, 32'h0002_0143);
    wsync(1);
    @(posedge ce_pass_start);
    q.delete();
    // Request lasts one cycle only; the next write clears it
    @(posedge mclk);
    reg_wdata <= 32'h0002_01c3;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wdata <= 32'h0002_0143;
    @(posedge mclk);
    reg_wr <= 1'b0;
    wsync(3);
    chk(q.size(), 9);
    foreach (exp9[i]) chk(q[i], exp9[i]);
    chk(chop_polarity, 1'b0);
    wr(16'h2020, 32'h0002_0243);
    wsync(1);
    chk(chop_polarity, 1'b1);
    wr(16'h2020, 32'h0002_0343);
    wsync(1);
    p = chop_polarity;
    wsync(1);
    chk(chop_polarity != p, 1'b1);
    wr(16'h2020, 32'h0002_0043);
    wsync(1);
    pq.delete();
    q.delete();
    cq.delete();
    wsync(4);
    chk(pq.size(), 2);
    chk(pq[0] != pq[1], 1'b1);
    // The frame before a forced alternate frame keeps its polarity
    for (int k = 1; k < q.size(); k++) begin
      if (q[k] == 4'ha) begin
        chk(cq[k], cq[k - 1]);
      end
    end
    wr(16'h2020, 32'h0002_6143);
    wsync(1);
    p = phase_b_return_swap;
    wsync(1);
    chk(phase_b_return_swap != p, 1'b1);
    chk(phase_a_return_swap, 1'b0);
    foreach (gaps[i]) begin
      wr(16'h2020, {24'h0002_01, 2'b00, gaps[i][13:12], 4'h3});
      filter_delay <= gaps[i][11:4] == 8'h35 ? 8'h3c : 8'h03;
      wsync(1);
      @(posedge ce_pass_start);
      @(negedge mclk);
      gap = 0;
      do begin
        @(negedge mclk);
        gap++;
      end while (filter_go !== 1'b1 && gap < 400);
      chk(gap, {24'h0, gaps[i][7:0]});
    end
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire

/* src/ams_seq.v */
/*
  Input multiplexer sequencer: steps the slot list once per frame, starts one
  filter conversion per slot, stores results into compute-engine RAM, runs
  alternate frames on request or forced by chop mode, and chops the reference.
  Assumes the slow crystal clock arrives as a pin from another domain and the
  filter, RAM and register master all run on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ams_seq_regs.vh"

// Notes on behaviour
// - Frames start at slot 0 and convert states_per_frame slots, 1 to 10.
// - Slot picks normal select in normal frames, alternate select in alternate.
// - Alternate request rising edge runs one alternate frame at next boundary.
// - A request held for one processor cycle only is still caught.
// - Sequencer steps on the slow clock; each slot starts on its rising edge.
// - Every slot sends a go command to the decimation filter.
// - After filter finished, advance on the next slow rising edge, but not before length + 1 slow cycles.
// - Filter length 0, 1, 2 gives conversions of 1, 2, 3 slow cycles.
// - Rate pair 01 gives 19/22/24 bits, otherwise 18/21/22 bits.
// - Results go to the RAM word fixed by the selected input.
// - Results are stored LSB aligned, shifted left by eight bits.
// - Battery path is on only while battery_measure_enable is set.
// - Control drives mux advance, filter start, chopping, and engine passes.
// - Each current pair has its own differential select bit.
// - Differential chopping swaps the return-tied current pin every frame.
// - One extra slow cycle after last slot: sync high, polarity updated.
// - Chop 01 low, 10 high, 00 toggle plus forced alternate, 11 toggle.
// - Mode 00 skips the toggle just before the forced alternate frame.
// - Compute-engine pass restarts each time slot 0 begins.
module ams_seq (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Register port
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Slow crystal clock pin
  input  wire        slow_crystal_clock,
  // Decimation filter
  output reg         filter_go,
  output reg  [1:0]  filter_length,
  output reg  [4:0]  result_width,
  input  wire        filter_finished,
  input  wire [23:0] filter_data,
  // Compute-engine RAM and program start
  output reg         ram_we,
  output reg  [3:0]  ram_addr,
  output reg  [31:0] ram_wdata,
  output reg         ce_pass_start,
  // Analog front end
  output reg  [3:0]  mux_select,
  output reg         chop_polarity,
  output reg         frame_sync_pulse,
  output reg         battery_path_enable,
  output reg         phase_a_differential,
  output reg         phase_b_differential,
  output reg         phase_a_return_swap,
  output reg         phase_b_return_swap
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_CONV = 2'd1;
  localparam [1:0] ST_SYNC = 2'd2;

  reg  [31:0] ctrl;
  reg  [3:0]  slot_sel     [0:`AMS_SLOTS-1];
  reg  [3:0]  slot_alt_sel [0:`AMS_SLOTS-1];
  reg         slow_s1;
  reg         slow_s2;
  reg         slow_s3;
  reg  [1:0]  state;
  reg  [3:0]  slot;
  reg         alt_frame;
  reg         alt_pending;
  reg  [7:0]  frame_cnt;
  reg         done_seen;
  reg  [1:0]  conv_cnt;
  reg         cur_phase;
  reg  [3:0]  cur_input;
  integer     i;

  wire        slow_rise = slow_s2 & ~slow_s3;
  wire [3:0]  spf       = ctrl[`AMS_SPF_LSB +: 4];
  wire [1:0]  flen      = ctrl[`AMS_FLEN_LSB +: 2];
  wire [1:0]  chop_mode = ctrl[`AMS_CHOP_LSB +: 2];
  wire [7:0]  ivl       = ctrl[`AMS_IVL_LSB +: 8];
  wire [3:0]  last_slot = (spf == 4'h0) ? 4'h0 :
                          (spf > 4'hA) ? 4'h9 : spf - 4'h1;
  wire [7:0]  ivl_last  = (ivl == 8'h00) ? 8'h00 : ivl - 8'h01;
  wire [7:0]  next_frame_cnt = (frame_cnt >= ivl_last) ? 8'h00 : frame_cnt + 8'h01;
  // The frame count stays that of the running frame until the next start, so
  // at a frame end this also marks the frame just before a forced alternate one
  wire        forced_now  = (chop_mode == `AMS_CHOP_TOGGLE_ALT) && (frame_cnt == ivl_last);
  // Only the 01 rate pair gives the longer results
  wire        rate_long = !ctrl[`AMS_HIRATE_BIT] && ctrl[`AMS_MIDRATE_BIT];
  wire        alt_rise = reg_wr && (reg_addr == `AMS_CTRL_OFS) &&
                         reg_wdata[`AMS_ALTREQ_BIT] && !ctrl[`AMS_ALTREQ_BIT];
  wire        conv_over = (done_seen | filter_finished) && (conv_cnt >= flen);
  // Slot words sit clear of the control word so all ten slots stay reachable
  wire        slot_win = (reg_addr >= `AMS_SLOT0_OFS) && (reg_addr < `AMS_SLOT_END_OFS) &&
                         (reg_addr[1:0] == 2'b00);
  wire        slot_wr  = reg_wr && slot_win;
  wire [3:0]  slot_idx = reg_addr[5:2];
  wire [3:0]  rd_idx   = reg_addr[5:2];

  // Register writes; the request bit is stored so its rising edge can be seen
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= `AMS_CTRL_RST;
      for (i = 0; i < `AMS_SLOTS; i = i + 1) begin
        slot_sel[i]     <= `AMS_SLOT_RST;
        slot_alt_sel[i] <= `AMS_SLOT_RST;
      end
    end else begin
      if (reg_wr && reg_addr == `AMS_CTRL_OFS) begin
        ctrl <= reg_wdata;
      end
      if (slot_wr && slot_idx < `AMS_SLOTS) begin
        slot_sel[slot_idx]     <= reg_wdata[3:0];
        slot_alt_sel[slot_idx] <= reg_wdata[7:4];
      end
    end
  end

  // Register reads, data in the cycle after the strobe only
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == `AMS_CTRL_OFS) begin
        reg_rdata <= ctrl;
      end else if (reg_addr == `AMS_STATUS_OFS) begin
        // Width [14:10], state [9:8], pending [6], polarity [5],
        // alternate frame [4], slot [3:0]
        reg_rdata <= {17'h0_0000, result_width, state, 1'b0, alt_pending,
                      chop_polarity, alt_frame, slot};
      end else if (slot_win && rd_idx < `AMS_SLOTS) begin
        reg_rdata <= {24'h00_0000, slot_alt_sel[rd_idx], slot_sel[rd_idx]};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Slow clock pin synchroniser; only the second and third stages are compared
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= slow_crystal_clock;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end

  // Selected input for the slot about to start; a list shortened in
  // mid-frame must not walk past slot 9, hence less-than
  always @* begin
    cur_input = 4'h0;
    if (state == ST_CONV && slot < last_slot) begin
      cur_input = alt_frame ? slot_alt_sel[slot + 4'h1] : slot_sel[slot + 4'h1];
    end else begin
      cur_input = (alt_pending | forced_now) ? slot_alt_sel[0] : slot_sel[0];
    end
  end

  // Sequencer, stepping only on slow clock rising edges
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      slot             <= 4'h0;
      alt_frame        <= 1'b0;
      alt_pending      <= 1'b0;
      frame_cnt        <= 8'h00;
      done_seen        <= 1'b0;
      conv_cnt         <= 2'b00;
      cur_phase        <= 1'b0;
      chop_polarity    <= 1'b0;
      frame_sync_pulse <= 1'b0;
      filter_go        <= 1'b0;
      ce_pass_start    <= 1'b0;
      mux_select       <= 4'h0;
    end else begin
      filter_go     <= 1'b0;
      ce_pass_start <= 1'b0;
      if (filter_finished) begin
        done_seen <= 1'b1;
      end
      // Request is caught on the write itself, so a one-cycle pulse suffices
      if (alt_rise) begin
        alt_pending <= 1'b1;
      end
      if (slow_rise) begin
        case (state)
          ST_IDLE, ST_SYNC: begin
            // Frame boundary: slot 0 starts, engine pass restarts
            frame_sync_pulse <= 1'b0;
            state            <= ST_CONV;
            slot             <= 4'h0;
            alt_frame        <= alt_pending | forced_now;
            frame_cnt        <= next_frame_cnt;
            // A new request in the start cycle wins over the clear
            if (!alt_rise) begin
              alt_pending <= 1'b0;
            end
            mux_select    <= cur_input;
            filter_go     <= 1'b1;
            ce_pass_start <= 1'b1;
            done_seen     <= 1'b0;
            conv_cnt      <= 2'b00;
          end
          ST_CONV: begin
            if (conv_over) begin
              done_seen <= 1'b0;
              conv_cnt  <= 2'b00;
              // At or past the end, so a shortened list still closes the frame
              if (slot >= last_slot) begin
                state            <= ST_SYNC;
                frame_sync_pulse <= 1'b1;
                cur_phase        <= ~cur_phase;
                case (chop_mode)
                  `AMS_CHOP_LOW:    chop_polarity <= 1'b0;
                  `AMS_CHOP_HIGH:   chop_polarity <= 1'b1;
                  `AMS_CHOP_TOGGLE: chop_polarity <= ~chop_polarity;
                  default: begin
                    // Hold polarity into a forced frame so those frames alternate
                    if (!forced_now) begin
                      chop_polarity <= ~chop_polarity;
                    end
                  end
                endcase
              end else begin
                slot       <= slot + 4'h1;
                mux_select <= cur_input;
                filter_go  <= 1'b1;
              end
            end else if (conv_cnt != 2'b11) begin
              conv_cnt <= conv_cnt + 2'b01;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Result store: the RAM word is the selected input code
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_we    <= 1'b0;
      ram_addr  <= 4'h0;
      ram_wdata <= 32'h0000_0000;
    end else begin
      // A finished pulse outside a conversion is stale and must not reach RAM
      ram_we <= filter_finished && (state == ST_CONV);
      if (filter_finished) begin
        ram_addr  <= mux_select;
        ram_wdata <= {filter_data, 8'h00};
      end
    end
  end

  // Front-end controls from the control register; return swaps also follow the frame phase
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      filter_length        <= 2'b00;
      result_width         <= 5'd18;
      battery_path_enable  <= 1'b0;
      phase_a_differential <= 1'b0;
      phase_b_differential <= 1'b0;
      phase_a_return_swap  <= 1'b0;
      phase_b_return_swap  <= 1'b0;
    end else begin
      filter_length       <= flen;
      battery_path_enable <= ctrl[`AMS_BATT_BIT];
      if (rate_long) begin
        result_width <= (flen == 2'd0) ? 5'd19 : (flen == 2'd1) ? 5'd22 : 5'd24;
      end else begin
        result_width <= (flen == 2'd0) ? 5'd18 : (flen == 2'd1) ? 5'd21 : 5'd22;
      end
      phase_a_differential <= ctrl[`AMS_DIFFA_BIT];
      phase_b_differential <= ctrl[`AMS_DIFFB_BIT];
      // Swap only makes sense in differential mode with chopping on
      phase_a_return_swap <= ctrl[`AMS_DIFFA_BIT] & ctrl[`AMS_CURCHOP_BIT] & cur_phase;
      phase_b_return_swap <= ctrl[`AMS_DIFFB_BIT] & ctrl[`AMS_CURCHOP_BIT] & cur_phase;
    end
  end

endmodule // ams_seq
`default_nettype wire

/* src/ams_seq_regs.vh */
/*
  Register offsets, field positions, reset values and timing figures of the
  input multiplexer sequencer.
  Assumes byte addressing on a 32-bit register port, one register per word.
*/
`ifndef AMS_SEQ_REGS_VH
`define AMS_SEQ_REGS_VH

// Byte offsets
`define AMS_SLOT0_OFS       16'h2040
`define AMS_SLOT_END_OFS    16'h2068
`define AMS_CTRL_OFS        16'h2020
`define AMS_STATUS_OFS      16'h2024

// Control register fields
`define AMS_SPF_LSB         0
`define AMS_FLEN_LSB        4
`define AMS_BATT_BIT        6
`define AMS_ALTREQ_BIT      7
`define AMS_CHOP_LSB        8
`define AMS_HIRATE_BIT      10
`define AMS_MIDRATE_BIT     11
`define AMS_DIFFA_BIT       12
`define AMS_DIFFB_BIT       13
`define AMS_CURCHOP_BIT     14
`define AMS_IVL_LSB         16

// Reset values
`define AMS_CTRL_RST        32'h0002_0004
`define AMS_SLOT_RST        4'h0

// Slot list and chop codes
`define AMS_SLOTS           10
`define AMS_CHOP_TOGGLE_ALT 2'b00
`define AMS_CHOP_LOW        2'b01
`define AMS_CHOP_HIGH       2'b10
`define AMS_CHOP_TOGGLE     2'b11

// Slow clock rate and the fastest master clock it is sampled by
`define AMS_SLOW_HZ         32768
`define AMS_MCLK_HZ         40000000

`endif
